/* File: src/iols_status_regs.sv */
//
// Read-only status register bank: digital I/O images, level and
// setpoint flags, analog output values and scale input signals.
// Assumes a protocol engine on CLK_SYS presents one request at a time
// and that outputs, weight, limits and setpoint flags are synchronous.
//
`timescale 1ns/10ps
module iols_status_regs
    import iols_pkg::*;
(
    // Clock, reset and enable
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic CE,
    // Digital input pins, bit k-1 is the k-th input in 11..68 order
    input wire logic [IOLS_NUM_DIO-1:0] DIN_PIN,
    // Digital output states from the output logic
    input wire logic [IOLS_NUM_DIO-1:0] DOUT_STATE,
    // Weight and level limits
    input wire iols_pkg::iols_word32_t WEIGHT,
    input wire iols_pkg::iols_word32_t LEVEL_LIMIT [IOLS_NUM_LEVELS],
    // Setpoint state
    input wire logic [IOLS_NUM_SETPOINTS-1:0] SP_ACTIVE,
    input wire logic [IOLS_NUM_SETPOINTS-1:0] SP_DONE,
    // Analog drive values in millionths, scale signals in uV/V
    input wire iols_pkg::iols_word32_t AOUT_VALUE [IOLS_NUM_AOUT],
    input wire iols_pkg::iols_word32_t SCALE_SIGNAL [IOLS_NUM_SCALES],
    // Register request and answer
    input wire iols_pkg::iols_req_t REQ,
    output iols_pkg::iols_rsp_t RSP
);

    import iols_pkg::*;

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    // Classifies a word address; used by the read path only.
    function automatic iols_cls_t addr_class(input logic [7:0] a);
        iols_cls_t c;
        c = IOLS_CLS_NONE;
        if (a <= IOLS_ADDR_SP_HI)
            c = IOLS_CLS_STATUS;
        else if (a >= IOLS_ADDR_AOUT_BASE &&
                 a < IOLS_ADDR_AOUT_BASE + 8'(2 * IOLS_NUM_AOUT))
            c = IOLS_CLS_AOUT;
        else if (a >= IOLS_ADDR_SIG_BASE &&
                 a < IOLS_ADDR_SIG_BASE + 8'(2 * IOLS_NUM_SCALES))
            c = IOLS_CLS_SIG;
        return c;
    endfunction : addr_class

    // Rounds a value in millionths to thousandths, halves away from 0.
    function automatic iols_word32_t round_milli(input iols_word32_t v);
        logic [31:0] mag;
        logic [31:0] q;
        mag = v[31] ? 32'(-v) : 32'(v);
        q = (mag + IOLS_MILLI_HALF) / IOLS_MILLI_DIV;
        return v[31] ? iols_word32_t'(-q) : iols_word32_t'(q);
    endfunction : round_milli

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic [IOLS_NUM_DIO-1:0] din_clean;
    logic [IOLS_NUM_DIO-1:0] din_img_ff;
    logic [IOLS_NUM_DIO-1:0] dout_img_ff;
    logic [IOLS_NUM_LEVELS-1:0] nxt_lvl;
    logic [IOLS_NUM_LEVELS-1:0] lvl_ff;
    logic [2*IOLS_NUM_SETPOINTS-1:0] nxt_sp;
    logic [2*IOLS_NUM_SETPOINTS-1:0] sp_ff;
    iols_word32_t aout_ff [IOLS_NUM_AOUT];
    iols_word32_t sig_ff [IOLS_NUM_SCALES];
    iols_rsp_t rsp_ff;
    iols_rsp_t nxt_rsp;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    iols_sync u_sync (
        .CLK_SYS(CLK_SYS),
        .ARST_N(ARST_N),
        .CE(CE),
        .PIN_IN(DIN_PIN),
        .CLEAN_OUT(din_clean)
    );

    // ------------------------------------------------------------
    // Level and setpoint flag formation
    // ------------------------------------------------------------
    // Level n+1 sits on flag bit n; bits 16-31 form the high word.
    // Strictly greater: a weight equal to the limit is not above it.
    genvar gl;
    generate
        for (gl = 0; gl < IOLS_NUM_LEVELS; gl++)
        begin : g_lvl
            assign nxt_lvl[gl] = (WEIGHT > LEVEL_LIMIT[gl]);
        end
        for (gl = 0; gl < IOLS_NUM_SETPOINTS; gl++)
        begin : g_sp
            // Pairs: activated on the even bit, cycle done on the odd.
            assign nxt_sp[2*gl+IOLS_SP_ACT_POS] = SP_ACTIVE[gl];
            assign nxt_sp[2*gl+IOLS_SP_DONE_POS] = SP_DONE[gl];
        end
    endgenerate

    // ------------------------------------------------------------
    // Status images
    // ------------------------------------------------------------
    // Images are refreshed every enabled cycle so a read always sees
    // a coherent copy one cycle old; nothing on the request path can
    // load them, which keeps the bank read-only.
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            din_img_ff <= '0;
            dout_img_ff <= '0;
            lvl_ff <= '0;
            sp_ff <= '0;
        end
        else if (CE)
        begin
            din_img_ff <= din_clean;
            dout_img_ff <= DOUT_STATE;
            lvl_ff <= nxt_lvl;
            sp_ff <= nxt_sp;
        end
    end

    // Analog values rounded at capture time, scale signals taken as is.
    genvar ga;
    generate
        for (ga = 0; ga < IOLS_NUM_AOUT; ga++)
        begin : g_aout
            always_ff @(posedge CLK_SYS or negedge ARST_N)
            begin
                if (!ARST_N)
                    aout_ff[ga] <= '0;
                else if (CE)
                    aout_ff[ga] <= round_milli(AOUT_VALUE[ga]);
            end
        end
        for (ga = 0; ga < IOLS_NUM_SCALES; ga++)
        begin : g_sig
            always_ff @(posedge CLK_SYS or negedge ARST_N)
            begin
                if (!ARST_N)
                    sig_ff[ga] <= '0;
                else if (CE)
                    sig_ff[ga] <= SCALE_SIGNAL[ga];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    // Word A holds image bits 0-15, word B bits 16-31, word C bits 32-47.
    wire [15:0] w_in_a = din_img_ff[15:0];
    wire [15:0] w_in_b = din_img_ff[31:16];
    wire [15:0] w_in_c = din_img_ff[47:32];
    wire [15:0] w_out_a = dout_img_ff[15:0];
    wire [15:0] w_out_b = dout_img_ff[31:16];
    wire [15:0] w_out_c = dout_img_ff[47:32];
    wire [15:0] w_lvl_lo = lvl_ff[15:0];
    wire [15:0] w_lvl_hi = lvl_ff[31:16];
    wire [15:0] w_sp_lo = sp_ff[15:0];
    wire [15:0] w_sp_hi = sp_ff[31:16];

    wire iols_cls_t req_cls = addr_class(REQ.addr);
    wire [7:0] aout_off = REQ.addr - IOLS_ADDR_AOUT_BASE;
    wire [7:0] sig_off = REQ.addr - IOLS_ADDR_SIG_BASE;
    wire [1:0] aout_idx = aout_off[2:1];
    wire [2:0] sig_idx = sig_off[3:1];
    wire [31:0] aout_sel = aout_ff[aout_idx];
    wire [31:0] sig_sel = sig_ff[sig_idx];
    wire [15:0] aout_word = aout_off[0] ? aout_sel[15:0] : aout_sel[31:16];
    wire [15:0] sig_word = sig_off[0] ? sig_sel[15:0] : sig_sel[31:16];

    logic [15:0] status_word;
    always_comb
    begin
        case (REQ.addr)
            IOLS_ADDR_IN_A: status_word = w_in_a;
            IOLS_ADDR_IN_B: status_word = w_in_b;
            IOLS_ADDR_IN_C: status_word = w_in_c;
            IOLS_ADDR_OUT_A: status_word = w_out_a;
            IOLS_ADDR_OUT_B: status_word = w_out_b;
            IOLS_ADDR_OUT_C: status_word = w_out_c;
            IOLS_ADDR_LVL_LO: status_word = w_lvl_lo;
            IOLS_ADDR_LVL_HI: status_word = w_lvl_hi;
            IOLS_ADDR_SP_LO: status_word = w_sp_lo;
            IOLS_ADDR_SP_HI: status_word = w_sp_hi;
            default: status_word = IOLS_RESET_WORD;
        endcase
    end

    // ------------------------------------------------------------
    // Answer formation
    // ------------------------------------------------------------
    // A read of a mapped word answers with data; a read of a hole or
    // any write answers with err and zero data. A write never reaches
    // storage, the images only follow the hardware. A request with
    // both rd and wr set is treated as a write and refused.
    always_comb
    begin
        nxt_rsp = '0;
        if (REQ.wr)
        begin
            nxt_rsp.valid = 1'b1;
            nxt_rsp.err = 1'b1;
        end
        else if (REQ.rd)
        begin
            nxt_rsp.valid = 1'b1;
            case (req_cls)
                IOLS_CLS_STATUS: nxt_rsp.data = status_word;
                IOLS_CLS_AOUT: nxt_rsp.data = aout_word;
                IOLS_CLS_SIG: nxt_rsp.data = sig_word;
                default: nxt_rsp.err = 1'b1;
            endcase
        end
    end

    // The answer is a registered one-cycle pulse; CE low holds it.
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            rsp_ff <= '0;
        else if (CE)
            rsp_ff <= nxt_rsp;
    end

    assign RSP = rsp_ff;

endmodule : iols_status_regs

/* File: include/iols_pkg.sv */
//
// Package for the I/O, level and setpoint status register bank.
// Assumes a protocol engine on the same clock that turns remote
// register reads and writes into single-cycle requests.
package iols_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int IOLS_AW = 8;
    localparam int IOLS_DW = 16;
    localparam int IOLS_NUM_DIO = 48;
    localparam int IOLS_NUM_LEVELS = 32;
    localparam int IOLS_NUM_SETPOINTS = 16;
    localparam int IOLS_NUM_AOUT = 4;
    localparam int IOLS_NUM_SCALES = 8;
    localparam int IOLS_SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IOLS_ADDR_IN_A = 8'h00;
    localparam logic [7:0] IOLS_ADDR_IN_B = 8'h01;
    localparam logic [7:0] IOLS_ADDR_IN_C = 8'h02;
    localparam logic [7:0] IOLS_ADDR_OUT_A = 8'h03;
    localparam logic [7:0] IOLS_ADDR_OUT_B = 8'h04;
    localparam logic [7:0] IOLS_ADDR_OUT_C = 8'h05;
    localparam logic [7:0] IOLS_ADDR_LVL_LO = 8'h06;
    localparam logic [7:0] IOLS_ADDR_LVL_HI = 8'h07;
    localparam logic [7:0] IOLS_ADDR_SP_LO = 8'h08;
    localparam logic [7:0] IOLS_ADDR_SP_HI = 8'h09;
    // Analog values: two words each, high word at the even address.
    localparam logic [7:0] IOLS_ADDR_AOUT_BASE = 8'h10;
    // Scale input signals: two words each, high word first.
    localparam logic [7:0] IOLS_ADDR_SIG_BASE = 8'h20;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int IOLS_BANK_BITS = 8;
    localparam int IOLS_HI_BANK_POS = 8;
    localparam int IOLS_SP_ACT_POS = 0;
    localparam int IOLS_SP_DONE_POS = 1;
    localparam logic [31:0] IOLS_MILLI_DIV = 32'h0000_03E8;
    localparam logic [31:0] IOLS_MILLI_HALF = 32'h0000_01F4;
    localparam logic [15:0] IOLS_RESET_WORD = 16'h0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef logic signed [31:0] iols_word32_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [IOLS_AW-1:0] addr;
        logic [IOLS_DW-1:0] wdata;
    } iols_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [IOLS_DW-1:0] data;
    } iols_rsp_t;

    typedef enum logic [1:0] {
        IOLS_CLS_NONE,
        IOLS_CLS_STATUS,
        IOLS_CLS_AOUT,
        IOLS_CLS_SIG
    } iols_cls_t;

endpackage : iols_pkg

/* File: src/iols_sync.sv */
//
// Synchroniser bank for the digital input pins.
// Assumes asynchronous pins; the clock enable freezes every stage.
//
`timescale 1ns/10ps
module iols_sync
    import iols_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic CE,
    // Pin side
    input wire logic [IOLS_NUM_DIO-1:0] PIN_IN,
    // Clean side
    output logic [IOLS_NUM_DIO-1:0] CLEAN_OUT
);

    logic [IOLS_NUM_DIO-1:0] meta_ff;
    logic [IOLS_NUM_DIO-1:0] sync2_ff;
    logic [IOLS_NUM_DIO-1:0] sync3_ff;
    logic [IOLS_NUM_DIO-1:0] clean_ff;

    // ------------------------------------------------------------
    // Per-bit three-stage chain
    // ------------------------------------------------------------
    // A bit is taken only when stages two and three agree, so a
    // single-cycle glitch that slipped past the first stage is ignored.
    genvar g;
    generate
        for (g = 0; g < IOLS_NUM_DIO; g++)
        begin : g_bit
            wire agree = (sync2_ff[g] == sync3_ff[g]);
            always_ff @(posedge CLK_SYS or negedge ARST_N)
            begin
                if (!ARST_N)
                begin
                    meta_ff[g] <= 1'b0;
                    sync2_ff[g] <= 1'b0;
                    sync3_ff[g] <= 1'b0;
                    clean_ff[g] <= 1'b0;
                end
                else if (CE)
                begin
                    meta_ff[g] <= PIN_IN[g];
                    sync2_ff[g] <= meta_ff[g];
                    sync3_ff[g] <= sync2_ff[g];
                    if (agree)
                        clean_ff[g] <= sync3_ff[g];
                end
            end
        end
    endgenerate

    assign CLEAN_OUT = clean_ff;

endmodule : iols_sync

/* File: tb/iols_status_properties.sv */
// Checker for the status bank: answer timing, refusals and field images.
// Assumes CE is high around the requests whose data it checks.
`timescale 1ns/10ps
module iols_status_props
    import iols_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic CE,
    // Watched inputs
    input wire logic [IOLS_NUM_DIO-1:0] DOUT_STATE,
    input wire iols_pkg::iols_word32_t WEIGHT,
    input wire iols_pkg::iols_word32_t LEVEL_LIMIT [IOLS_NUM_LEVELS],
    input wire logic [IOLS_NUM_SETPOINTS-1:0] SP_ACTIVE,
    input wire logic [IOLS_NUM_SETPOINTS-1:0] SP_DONE,
    // Request and answer
    input wire iols_pkg::iols_req_t REQ,
    input wire iols_pkg::iols_rsp_t RSP
);
    // Request decodes; rd and wr together count as a write.
    wire logic rq = REQ.rd | REQ.wr;
    wire logic rd = REQ.rd & ~REQ.wr;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    property p_answer;
        CE && rq ##1 CE |-> RSP.valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_idle;
        CE && !rq ##1 CE |-> !RSP.valid;
    endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_wr_refused;
        CE && REQ.wr ##1 CE |-> RSP.err && RSP.data == 16'h0000;
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("write taken");
    property p_unmapped;
        CE && rd && REQ.addr > 8'h2F ##1 CE |-> RSP.err && RSP.data == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad address");
    property p_mapped_ok;
        CE && rd && REQ.addr <= IOLS_ADDR_SP_HI ##1 CE |-> !RSP.err;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("read refused");
    // Images lag their inputs by one edge, so data matches two edges back.
    property p_out_a;
        CE[*2] ##1 CE && rd && REQ.addr == IOLS_ADDR_OUT_A ##1 CE
            |-> RSP.data == $past(DOUT_STATE[15:0], 2);
    endproperty
    a_out_a: assert property (p_out_a) else $error("output word");
    property p_sp_lo;
        CE[*2] ##1 CE && rd && REQ.addr == IOLS_ADDR_SP_LO ##1 CE
            |-> RSP.data[1:0] == {$past(SP_DONE[0], 2), $past(SP_ACTIVE[0], 2)}
            && RSP.data[15] == $past(SP_DONE[7], 2);
    endproperty
    a_sp_lo: assert property (p_sp_lo) else $error("setpoint word");
    property p_lvl_lo;
        CE[*2] ##1 CE && rd && REQ.addr == IOLS_ADDR_LVL_LO ##1 CE
            |-> RSP.data[0] == ($past(WEIGHT, 2) > $past(LEVEL_LIMIT[0], 2));
    endproperty
    a_lvl_lo: assert property (p_lvl_lo) else $error("level word");
endmodule : iols_status_props

bind iols_status_regs iols_status_props u_props (
    .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CE(CE), .DOUT_STATE(DOUT_STATE),
    .WEIGHT(WEIGHT), .LEVEL_LIMIT(LEVEL_LIMIT), .SP_ACTIVE(SP_ACTIVE),
    .SP_DONE(SP_DONE), .REQ(REQ), .RSP(RSP)
);

/* File: tb/iols_master_model.sv */
// Remote master model: one request per go pulse, answer kept until next.
// Assumes the bank answers with a one-cycle valid pulse on clk_sys.
`timescale 1ns/10ps
module iols_master_model
    import iols_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Bench side
    input wire logic go,
    input wire iols_pkg::iols_req_t cmd,
    output iols_pkg::iols_rsp_t got_ff,
    output logic done_ff,
    // Bank side
    output iols_pkg::iols_req_t req_ff,
    input wire iols_pkg::iols_rsp_t rsp
);
    // Strobe lasts one cycle; idle cycles carry no request at all.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_ff <= '0;
            got_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            req_ff <= go ? cmd : '0;
            done_ff <= rsp.valid;
            if (rsp.valid)
                got_ff <= rsp;
        end
    end
endmodule : iols_master_model

/* File: tb/iols_status_tb.sv */
// Bench for the status bank: drives I/O images, levels, setpoints and
// analog values, then reads every word through the master model.
`timescale 1ns/10ps
module io_level_setpoint_status_regs_tb_top;
    import iols_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic go = 1'b0;
    logic done;
    logic [IOLS_NUM_DIO-1:0] din_pin = 48'h9A3C_5E71_F00F;
    logic [IOLS_NUM_DIO-1:0] dout_state = 48'hC3A5_0FF0_8E17;
    logic [IOLS_NUM_SETPOINTS-1:0] sp_active = 16'hA5F0;
    logic [IOLS_NUM_SETPOINTS-1:0] sp_done = 16'h3C81;
    iols_word32_t weight = 32'h0000_0640;
    iols_word32_t level_limit [IOLS_NUM_LEVELS];
    iols_word32_t aout_value [IOLS_NUM_AOUT];
    iols_word32_t scale_signal [IOLS_NUM_SCALES];
    iols_req_t cmd = '0;
    iols_req_t req;
    iols_rsp_t rsp;
    iols_rsp_t got;
    logic [15:0] w;
    logic [7:0] ad;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;

    iols_master_model u_master (.clk_sys(clk_sys), .arst_n(arst_n),
        .go(go), .cmd(cmd), .got_ff(got), .done_ff(done), .req_ff(req),
        .rsp(rsp));
    iols_status_regs dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce),
        .DIN_PIN(din_pin), .DOUT_STATE(dout_state), .WEIGHT(weight),
        .LEVEL_LIMIT(level_limit), .SP_ACTIVE(sp_active), .SP_DONE(sp_done),
        .AOUT_VALUE(aout_value), .SCALE_SIGNAL(scale_signal), .REQ(req),
        .RSP(rsp));

    // 125 MHz clock; the cycle counter cuts a hang short.
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt = error_cnt + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One transfer; the answer is due a fixed two edges after the strobe.
    task automatic xfer(logic r, logic wr, logic [7:0] a, logic [15:0] d);
        @(posedge clk_sys);
        go <= 1'b1;
        cmd <= '{rd: r, wr: wr, addr: a, wdata: d};
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("answer", {16'h0000, done}, 17'h0_0001);
    endtask : xfer

    task automatic rd(string what, logic [7:0] a, logic [16:0] exp);
        xfer(1'b1, 1'b0, a, 16'h0000);
        check(what, {got.err, got.data}, exp);
    endtask : rd

    // A 32-bit value sits high word first at the even address.
    task automatic rd32(string what, logic [7:0] a, iols_word32_t v);
        rd(what, a, {1'b0, v[31:16]});
        rd(what, a + 8'h01, {1'b0, v[15:0]});
    endtask : rd32

    // Thousandths, rounded half away from zero.
    function automatic iols_word32_t milli(iols_word32_t x);
        return x < 0 ? -((-x + 32'sh1F4) / 32'sh3E8) : (x + 32'sh1F4) / 32'sh3E8;
    endfunction : milli

    initial
    begin
        aout_value = '{32'sh0012_D687, -32'sh0000_09C4, 32'sh0000_05DB,
            32'sh7FF8_9EC0};
        for (int k = 0; k < IOLS_NUM_LEVELS; k++)
            level_limit[k] = k * 100;
        for (int k = 0; k < IOLS_NUM_SCALES; k++)
            scale_signal[k] = k * 32'h1357_9BDF - 32'h4000_0000;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        // Writes, with and without rd, are refused and change nothing.
        for (int a = 0; a < 10; a++)
        begin
            xfer(a[0], 1'b1, 8'(a), 16'hFFFF);
            check("write", {got.err, got.data}, 17'h1_0000);
        end
        rd("unmapped", 8'h30, 17'h1_0000);
        rd("unmapped", 8'hFF, 17'h1_0000);
        for (int i = 0; i < 3; i++)
        begin
            w = din_pin[16*i +: 16];
            rd("inputs", 8'(IOLS_ADDR_IN_A + i), {1'b0, w});
            w = dout_state[16*i +: 16];
            rd("outputs", 8'(IOLS_ADDR_OUT_A + i), {1'b0, w});
        end
        for (int s = 0; s < 2; s++)
        begin
            for (int i = 0; i < 8; i++)
                w[2*i +: 2] = {sp_done[8*s+i], sp_active[8*s+i]};
            rd("setpoints", 8'(IOLS_ADDR_SP_LO + s), {1'b0, w});
        end
        // Weight exactly at level 17, then between levels 26 and 27.
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk_sys);
            weight <= p ? 32'h0000_09F6 : 32'h0000_0640;
            repeat (2) @(posedge clk_sys);
            for (int s = 0; s < 2; s++)
            begin
                for (int b = 0; b < 16; b++)
                    w[b] = weight > level_limit[16*s + b];
                rd("levels", 8'(IOLS_ADDR_LVL_LO + s), {1'b0, w});
            end
        end
        for (int k = 0; k < IOLS_NUM_SCALES; k++)
        begin
            ad = IOLS_ADDR_AOUT_BASE + 8'(2 * k);
            if (k < IOLS_NUM_AOUT)
                rd32("analog", ad, milli(aout_value[k]));
            ad = IOLS_ADDR_SIG_BASE + 8'(2 * k);
            rd32("signal", ad, scale_signal[k]);
        end
        // A short enable gap; the bank must answer normally afterwards.
        @(posedge clk_sys);
        ce <= 1'b0;
        repeat (3) @(posedge clk_sys);
        ce <= 1'b1;
        rd("after gap", IOLS_ADDR_OUT_A, {1'b0, dout_state[15:0]});
        wrap_up();
    end
endmodule : io_level_setpoint_status_regs_tb_top
